// [pkg/mgmt_port_pkg.sv]
// constants, widths and helpers shared by both ends of the management register port
package mgmt_port_pkg;

   // port geometry
   localparam int ADDR_W   = 6;
   localparam int DATA_W   = 8;
   localparam int NUM_REGS = 64;

   // register indices with special behaviour inside the device
   localparam logic [ADDR_W-1:0] CAUSE_IDX = 6'h05;
   localparam logic [ADDR_W-1:0] MASK_IDX  = 6'h06;

   // field position of the write parity error flag in the cause register
   localparam int PERR_BIT = 0;

   // reset values
   localparam logic [DATA_W-1:0] REG_RST   = 8'h00;
   localparam logic [DATA_W-1:0] CAUSE_RST = 8'h00;
   localparam logic [DATA_W-1:0] MASK_RST  = 8'h00;

   // read/write select encoding on the select line
   localparam logic SEL_READ  = 1'b1;
   localparam logic SEL_WRITE = 1'b0;

   // level seen on an undriven line thanks to the board pull-up
   localparam logic [DATA_W-1:0] PULLUP_DATA = 8'hff;
   localparam logic              PULLUP_BIT  = 1'b1;

   // level an open-drain output drives while its enable is low
   localparam logic OD_LOW = 1'b0;

   // device handshake states, gray along idle -> exec -> ack; ack -> idle flips both bits
   typedef enum logic [1:0] {
      DEV_IDLE = 2'b00,
      DEV_EXEC = 2'b01,
      DEV_ACK  = 2'b11
   } dev_state_e;

   // host handshake states, gray along idle -> setup -> wait_ack -> wait_rel
   typedef enum logic [1:0] {
      HOST_IDLE     = 2'b00,
      HOST_SETUP    = 2'b01,
      HOST_WAIT_ACK = 2'b11,
      HOST_WAIT_REL = 2'b10
   } host_state_e;

   // parity bit that makes the nine bits carry an odd number of ones
   function automatic logic odd_parity(input logic [DATA_W-1:0] data);
      return ~(^data);
   endfunction

   // true when data and parity together hold an odd count of ones
   function automatic logic parity_ok(input logic [DATA_W-1:0] data, input logic par);
      return (^data) ^ par;
   endfunction

endpackage

// [pkg/mgmt_port_if.sv]
// pins of the management register port, with wire resolution of the shared lines
`timescale 1ns/10ps
interface mgmt_port_if;
   import mgmt_port_pkg::*;

   // host driven inputs of the device
   logic              enable_n;
   logic              rd_wr_sel;
   logic [ADDR_W-1:0] mgmt_reg_addr;

   // two-way data and parity, one drive per end
   logic [DATA_W-1:0] host_data_o;
   logic              host_data_oe_n;
   logic              host_par_o;
   logic              host_par_oe_n;
   logic [DATA_W-1:0] dev_data_o;
   logic              dev_data_oe_n;
   logic              dev_par_o;
   logic              dev_par_oe_n;

   // open-drain acknowledge and interrupt from the device
   logic              ack_o;
   logic              ack_oe_n;
   logic              int_o;
   logic              int_oe_n;

   // resolved line levels
   logic [DATA_W-1:0] mgmt_data_lines;
   logic              mgmt_odd_parity;
   logic              ack_n;
   logic              int_n;

   // data and parity: device drive wins over host drive, else pull-up
   assign mgmt_data_lines = !dev_data_oe_n  ? dev_data_o  :
                            !host_data_oe_n ? host_data_o : PULLUP_DATA;
   assign mgmt_odd_parity = !dev_par_oe_n   ? dev_par_o   :
                            !host_par_oe_n  ? host_par_o  : PULLUP_BIT;

   // open-drain lines float high when released
   assign ack_n = !ack_oe_n ? ack_o : PULLUP_BIT;
   assign int_n = !int_oe_n ? int_o : PULLUP_BIT;

   modport dev (
      input  enable_n, rd_wr_sel, mgmt_reg_addr, mgmt_data_lines, mgmt_odd_parity,
      output dev_data_o, dev_data_oe_n, dev_par_o, dev_par_oe_n,
      output ack_o, ack_oe_n, int_o, int_oe_n
   );

   modport host (
      output enable_n, rd_wr_sel, mgmt_reg_addr,
      output host_data_o, host_data_oe_n, host_par_o, host_par_oe_n,
      input  mgmt_data_lines, mgmt_odd_parity, ack_n, int_n
   );

endinterface

// [rtl/mgmt_port_device.sv]
// device end of the management register port: 64 byte registers behind an enable/acknowledge handshake
//
// How it works
// (RQ1) sixty-four byte registers, six-bit address
// (RQ2) host sets select, address, data before enable
// (RQ3) select high reads, select low writes
// (RQ4) acknowledge pulled low marks cycle complete
// (RQ5) read data valid while acknowledge low
// (RQ6) host holds write data until acknowledge
// (RQ7) acknowledge stays low until enable released
// (RQ8) odd parity over data, both directions
// (RQ9) bad write parity blocks write, flags error
// (RQ10) interrupt line low while unmasked cause pending
// (RQ11) masked cause bits never raise interrupt
// (RQ12) address bit five is most significant
// (RQ13) data lines driven only during reads
`timescale 1ns/10ps
module mgmt_port_device (
   input  wire logic                              core_clk_i,
   input  wire logic                              rst_i,
   mgmt_port_if.dev                               port,
   input  wire logic [mgmt_port_pkg::DATA_W-1:0]  cond_event_i,
   output logic                                   wr_strobe_o,
   output logic      [mgmt_port_pkg::ADDR_W-1:0]  wr_addr_o,
   output logic      [mgmt_port_pkg::DATA_W-1:0]  wr_data_o,
   output logic                                   int_pending_o
);
   import mgmt_port_pkg::*;

   // synchroniser stages for every pin coming from the host
   logic              en_meta_reg;
   logic              en_sync_reg;
   logic              rw_meta_reg;
   logic              rw_sync_reg;
   logic [ADDR_W-1:0] addr_meta_reg;
   logic [ADDR_W-1:0] addr_sync_reg;
   logic [DATA_W-1:0] data_meta_reg;
   logic [DATA_W-1:0] data_sync_reg;
   logic              par_meta_reg;
   logic              par_sync_reg;

   // handshake state and line drivers
   dev_state_e        state_reg;
   dev_state_e        state_next;
   logic              ack_oe_n_reg;
   logic              data_oe_n_reg;
   logic [DATA_W-1:0] rd_data_reg;
   logic              rd_par_reg;
   logic              int_oe_n_reg;

   // register storage
   logic [DATA_W-1:0] regs_reg [0:NUM_REGS-1];
   logic [DATA_W-1:0] cause_reg;
   logic [DATA_W-1:0] cause_next;
   logic [DATA_W-1:0] mask_reg;

   // decoded cycle actions, valid in the execute state only; cause_set also takes cond_event_i in every state
   logic              exec_cycle;
   logic              do_read;
   logic              do_write;
   logic              parity_err;
   logic [DATA_W-1:0] cause_set;
   logic [DATA_W-1:0] cause_clr;

   // read view of one register; cause and mask live outside the array
   function automatic logic [DATA_W-1:0] reg_view(input logic [ADDR_W-1:0] idx);
      logic [DATA_W-1:0] val;
      val = regs_reg[idx];
      if (idx == CAUSE_IDX) begin
         val = cause_reg;
      end else if (idx == MASK_IDX) begin
         val = mask_reg;
      end
      return val;
   endfunction

   // two flip-flops on every host pin before any logic looks at it
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         en_meta_reg   <= 1'b1;
         en_sync_reg   <= 1'b1;
         rw_meta_reg   <= SEL_READ;
         rw_sync_reg   <= SEL_READ;
         addr_meta_reg <= '0;
         addr_sync_reg <= '0;
         data_meta_reg <= '0;
         data_sync_reg <= '0;
         par_meta_reg  <= 1'b0;
         par_sync_reg  <= 1'b0;
      end else begin
         en_meta_reg   <= port.enable_n;
         en_sync_reg   <= en_meta_reg;
         rw_meta_reg   <= port.rd_wr_sel;
         rw_sync_reg   <= rw_meta_reg;
         addr_meta_reg <= port.mgmt_reg_addr;   // RQ12
         addr_sync_reg <= addr_meta_reg;
         data_meta_reg <= port.mgmt_data_lines;
         data_sync_reg <= data_meta_reg;
         par_meta_reg  <= port.mgmt_odd_parity;
         par_sync_reg  <= par_meta_reg;
      end
   end

   // next handshake state: enable low starts, released enable ends
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         DEV_IDLE: begin
            if (!en_sync_reg) begin
               state_next = DEV_EXEC;   // RQ2
            end
         end
         DEV_EXEC: begin
            state_next = DEV_ACK;
         end
         DEV_ACK: begin
            if (en_sync_reg) begin
               state_next = DEV_IDLE;   // RQ7
            end
         end
         default: begin
            state_next = DEV_IDLE;
         end
      endcase
   end

   // state register
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         state_reg <= DEV_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // cycle decode; write data sampled while host still holds it  RQ6
   always_comb begin
      exec_cycle = (state_reg == DEV_EXEC);
      do_read    = exec_cycle && (rw_sync_reg == SEL_READ);    // RQ3
      do_write   = exec_cycle && (rw_sync_reg == SEL_WRITE)
                   && parity_ok(data_sync_reg, par_sync_reg);  // RQ8
      parity_err = exec_cycle && (rw_sync_reg == SEL_WRITE)
                   && !parity_ok(data_sync_reg, par_sync_reg); // RQ9
   end

   // acknowledge pulled low after the access, held until enable released
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         ack_oe_n_reg <= 1'b1;
      end else if (exec_cycle) begin
         ack_oe_n_reg <= 1'b0;   // RQ4
      end else if (state_reg == DEV_ACK && en_sync_reg) begin
         ack_oe_n_reg <= 1'b1;   // RQ7
      end
   end

   // read data and its parity captured once, stable through acknowledge
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         rd_data_reg <= REG_RST;
         rd_par_reg  <= odd_parity(REG_RST);
      end else if (do_read) begin
         rd_data_reg <= reg_view(addr_sync_reg);               // RQ5
         rd_par_reg  <= odd_parity(reg_view(addr_sync_reg));   // RQ8
      end
   end

   // data and parity lines driven only on reads, released with acknowledge
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         data_oe_n_reg <= 1'b1;
      end else if (do_read) begin
         data_oe_n_reg <= 1'b0;   // RQ13
      end else if (state_reg == DEV_ACK && en_sync_reg) begin
         data_oe_n_reg <= 1'b1;   // RQ13
      end
   end

   // plain register array; a blocked write leaves the target untouched
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < NUM_REGS; i++) begin
            regs_reg[i] <= REG_RST;   // RQ1
         end
      end else if (do_write) begin
         regs_reg[addr_sync_reg] <= data_sync_reg;   // RQ1 RQ9
      end
   end

   // mask register
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         mask_reg <= MASK_RST;
      end else if (do_write && addr_sync_reg == MASK_IDX) begin
         mask_reg <= data_sync_reg;
      end
   end

   // cause bits: events and parity error set, writing ones clears, set wins
   always_comb begin
      cause_set           = cond_event_i;
      cause_set[PERR_BIT] = cond_event_i[PERR_BIT] | parity_err;   // RQ9
      cause_clr           = (do_write && addr_sync_reg == CAUSE_IDX) ? data_sync_reg : '0;
      cause_next          = (cause_reg & ~cause_clr) | cause_set;
   end

   // cause register
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         cause_reg <= CAUSE_RST;
      end else begin
         cause_reg <= cause_next;
      end
   end

   // interrupt line pulled low while any unmasked cause is pending
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         int_oe_n_reg  <= 1'b1;
         int_pending_o <= 1'b0;
      end else begin
         int_oe_n_reg  <= ~|(cause_reg & mask_reg);   // RQ10 RQ11
         int_pending_o <= |(cause_reg & mask_reg);    // RQ10 RQ11
      end
   end

   // user-side notice of each accepted write
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         wr_strobe_o <= 1'b0;
         wr_addr_o   <= '0;
         wr_data_o   <= '0;
      end else begin
         wr_strobe_o <= do_write;
         if (do_write) begin
            wr_addr_o <= addr_sync_reg;
            wr_data_o <= data_sync_reg;
         end
      end
   end

   // pin drivers; open-drain outputs only ever pull low
   assign port.dev_data_o    = rd_data_reg;
   assign port.dev_data_oe_n = data_oe_n_reg;
   assign port.dev_par_o     = rd_par_reg;
   assign port.dev_par_oe_n  = data_oe_n_reg;
   assign port.ack_o         = OD_LOW;
   assign port.ack_oe_n      = ack_oe_n_reg;
   assign port.int_o         = OD_LOW;
   assign port.int_oe_n      = int_oe_n_reg;

endmodule

// [rtl/mgmt_port_host.sv]
// host end of the management register port: runs one read or write handshake per request
`timescale 1ns/10ps
module mgmt_port_host (
   input  wire logic                              core_clk_i,
   input  wire logic                              rst_i,
   mgmt_port_if.host                              port,
   input  wire logic                              req_i,
   input  wire logic                              req_read_i,
   input  wire logic [mgmt_port_pkg::ADDR_W-1:0]  req_addr_i,
   input  wire logic [mgmt_port_pkg::DATA_W-1:0]  req_wdata_i,
   input  wire logic                              req_bad_par_i,
   output logic                                   busy_o,
   output logic                                   done_o,
   output logic      [mgmt_port_pkg::DATA_W-1:0]  rdata_o,
   output logic                                   rdata_par_err_o,
   output logic                                   irq_o
);
   import mgmt_port_pkg::*;

   // synchronisers for device-driven pins
   logic              ack_meta_reg;
   logic              ack_sync_reg;
   logic              int_meta_reg;
   logic [DATA_W-1:0] data_meta_reg;
   logic [DATA_W-1:0] data_sync_reg;
   logic              par_meta_reg;
   logic              par_sync_reg;

   // handshake state and pin drivers
   host_state_e       state_reg;
   logic              enable_n_reg;
   logic              rw_reg;
   logic [ADDR_W-1:0] addr_reg;
   logic [DATA_W-1:0] wdata_reg;
   logic              wpar_reg;
   logic              drive_n_reg;

   // two flip-flops on every device pin
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         ack_meta_reg  <= 1'b1;
         ack_sync_reg  <= 1'b1;
         int_meta_reg  <= 1'b1;
         irq_o         <= 1'b0;
         data_meta_reg <= '0;
         data_sync_reg <= '0;
         par_meta_reg  <= 1'b0;
         par_sync_reg  <= 1'b0;
      end else begin
         ack_meta_reg  <= port.ack_n;
         ack_sync_reg  <= ack_meta_reg;
         int_meta_reg  <= port.int_n;
         irq_o         <= ~int_meta_reg;
         data_meta_reg <= port.mgmt_data_lines;
         data_sync_reg <= data_meta_reg;
         par_meta_reg  <= port.mgmt_odd_parity;
         par_sync_reg  <= par_meta_reg;
      end
   end

   // handshake sequencer: set up, enable, wait acknowledge, release, wait release
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         state_reg    <= HOST_IDLE;
         enable_n_reg <= 1'b1;
         drive_n_reg  <= 1'b1;
         rw_reg       <= SEL_READ;
         addr_reg     <= '0;
         wdata_reg    <= '0;
         wpar_reg     <= 1'b0;
         busy_o       <= 1'b0;
         done_o       <= 1'b0;
      end else begin
         done_o <= 1'b0;
         unique case (state_reg)
            HOST_IDLE: begin
               if (req_i) begin
                  state_reg   <= HOST_SETUP;
                  busy_o      <= 1'b1;
                  rw_reg      <= req_read_i ? SEL_READ : SEL_WRITE;   // RQ3
                  addr_reg    <= req_addr_i;                          // RQ12
                  wdata_reg   <= req_wdata_i;
                  wpar_reg    <= odd_parity(req_wdata_i) ^ req_bad_par_i;   // RQ8
                  drive_n_reg <= req_read_i;
               end
            end
            HOST_SETUP: begin
               state_reg    <= HOST_WAIT_ACK;
               enable_n_reg <= 1'b0;   // RQ2
            end
            HOST_WAIT_ACK: begin
               if (!ack_sync_reg) begin
                  state_reg    <= HOST_WAIT_REL;
                  enable_n_reg <= 1'b1;
                  drive_n_reg  <= 1'b1;   // RQ6
               end
            end
            HOST_WAIT_REL: begin
               if (ack_sync_reg) begin
                  state_reg <= HOST_IDLE;
                  busy_o    <= 1'b0;
                  done_o    <= 1'b1;
               end
            end
         endcase
      end
   end

   // read data captured while acknowledge holds it valid
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         rdata_o         <= '0;
         rdata_par_err_o <= 1'b0;
      end else if (state_reg == HOST_WAIT_ACK && !ack_sync_reg && rw_reg == SEL_READ) begin
         rdata_o         <= data_sync_reg;                            // RQ5
         rdata_par_err_o <= !parity_ok(data_sync_reg, par_sync_reg);  // RQ8
      end
   end

   // pin drivers
   assign port.enable_n       = enable_n_reg;
   assign port.rd_wr_sel      = rw_reg;
   assign port.mgmt_reg_addr  = addr_reg;
   assign port.host_data_o    = wdata_reg;
   assign port.host_data_oe_n = drive_n_reg;
   assign port.host_par_o     = wpar_reg;
   assign port.host_par_oe_n  = drive_n_reg;

endmodule

// [test/mgmt_port_asserts.sv]
// concurrent checks on the management port pins between host and device ends
`timescale 1ns/10ps
module mgmt_port_asserts (
   input wire logic                             core_clk_i,
   input wire logic                             rst_i,
   input wire logic                             enable_n,
   input wire logic                             rd_wr_sel,
   input wire logic [mgmt_port_pkg::ADDR_W-1:0] mgmt_reg_addr,
   input wire logic [mgmt_port_pkg::DATA_W-1:0] mgmt_data_lines,
   input wire logic                             mgmt_odd_parity,
   input wire logic                             dev_data_oe_n,
   input wire logic                             dev_par_oe_n,
   input wire logic                             ack_o,
   input wire logic                             ack_oe_n,
   input wire logic                             ack_n
);
   import mgmt_port_pkg::*;

   // one clock domain, checks idle during reset
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);

   // a cycle opens on the enable edge; the answer follows within a few cycles
   sequence cycle_open_s;
      $fell(enable_n);
   endsequence
   sequence ack_arrives_s;
      ack_n ##[1:5] !ack_n;
   endsequence

   ack_arrive_a: assert property (cycle_open_s |-> ack_arrives_s)
      else $error("acknowledge did not follow enable");
   ack_cause_a: assert property ($fell(ack_n) |-> !enable_n && !$past(enable_n, 2))
      else $error("acknowledge without a held enable");
   od_low_a: assert property (!ack_oe_n |-> ack_o == OD_LOW && !ack_n)
      else $error("acknowledge pin not pulled low");
   ack_hold_a: assert property (!ack_n && !enable_n |=> !ack_n)
      else $error("acknowledge dropped while enable low");
   ack_release_a: assert property ($rose(enable_n) |-> ##[1:5] ack_n)
      else $error("acknowledge not released after enable");
   rd_drive_a: assert property (!ack_n && rd_wr_sel == SEL_READ |-> !dev_data_oe_n && !dev_par_oe_n)
      else $error("read data not driven during acknowledge");
   rd_parity_a: assert property (!ack_n && rd_wr_sel == SEL_READ |-> ^{mgmt_data_lines, mgmt_odd_parity})
      else $error("read parity not odd");
   rd_stable_a: assert property (!ack_n && !$past(ack_n) && rd_wr_sel == SEL_READ
      |-> $stable(mgmt_data_lines) && $stable(mgmt_odd_parity))
      else $error("read data moved during acknowledge");
   dev_quiet_a: assert property (ack_n || rd_wr_sel == SEL_WRITE |-> dev_data_oe_n && dev_par_oe_n)
      else $error("device drives data outside a read");
   setup_a: assert property (cycle_open_s |-> $stable(rd_wr_sel) && $stable(mgmt_reg_addr))
      else $error("select or address changed with enable");
   wr_hold_a: assert property (!enable_n && rd_wr_sel == SEL_WRITE && ack_n
      |=> $stable(mgmt_data_lines) && $stable(mgmt_odd_parity))
      else $error("write data moved before acknowledge");
endmodule

// [test/tb_top.sv]
// self-checking bench: both port ends joined, checked against a register model
`timescale 1ns/10ps
module tb_top;
   import mgmt_port_pkg::*;

   logic              core_clk_i    = 1'b0;
   logic              rst_i         = 1'b1;
   logic              req_i         = 1'b0;
   logic              req_read_i    = 1'b0;
   logic              req_bad_par_i = 1'b0;
   logic [ADDR_W-1:0] req_addr_i    = 6'h00;
   logic [DATA_W-1:0] req_wdata_i   = 8'h00;
   logic [DATA_W-1:0] cond_event_i  = 8'h00;
   logic              busy_o, done_o, rdata_par_err_o, irq_o, wr_strobe_o, int_pending_o;
   logic [DATA_W-1:0] rdata_o, wr_data_o;
   logic [ADDR_W-1:0] wr_addr_o;
   int                bad_count = 0, samples_checked = 0, strobe_cnt = 0, cycles = 0;
   int                mem [NUM_REGS];
   int                cause = 0, mask = 0;
   logic [DATA_W-1:0] ev;

   mgmt_port_if port_if ();

   mgmt_port_device u_mgmt_port_device (.core_clk_i(core_clk_i), .rst_i(rst_i), .port(port_if),
      .cond_event_i(cond_event_i), .wr_strobe_o(wr_strobe_o), .wr_addr_o(wr_addr_o),
      .wr_data_o(wr_data_o), .int_pending_o(int_pending_o));
   mgmt_port_host u_mgmt_port_host (.core_clk_i(core_clk_i), .rst_i(rst_i), .port(port_if),
      .req_i(req_i), .req_read_i(req_read_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
      .req_bad_par_i(req_bad_par_i), .busy_o(busy_o), .done_o(done_o), .rdata_o(rdata_o),
      .rdata_par_err_o(rdata_par_err_o), .irq_o(irq_o));
   mgmt_port_asserts u_mgmt_port_asserts (.core_clk_i(core_clk_i), .rst_i(rst_i),
      .enable_n(port_if.enable_n), .rd_wr_sel(port_if.rd_wr_sel), .mgmt_reg_addr(port_if.mgmt_reg_addr),
      .mgmt_data_lines(port_if.mgmt_data_lines), .mgmt_odd_parity(port_if.mgmt_odd_parity),
      .dev_data_oe_n(port_if.dev_data_oe_n), .dev_par_oe_n(port_if.dev_par_oe_n),
      .ack_o(port_if.ack_o), .ack_oe_n(port_if.ack_oe_n), .ack_n(port_if.ack_n));

   // 200 MHz clock
   initial forever #2.5 core_clk_i = ~core_clk_i;

   // hang guard and write strobe counter
   always @(posedge core_clk_i) begin
      cycles++;
      if (wr_strobe_o === 1'b1) strobe_cnt++;
      if (cycles == 20000) begin
         bad_count++;
         $display("mismatch timeout expected done seen %0d cycles", cycles);
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      $display("counts: checked %0d mismatched %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk1(input string what, input logic exp, input logic got);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch %s expected %b seen %b", what, exp, got);
      end
   endtask

   // one host request, waits for done under a bound
   task automatic host_op(input logic rd, input logic [5:0] a, input logic [7:0] d, input logic bp);
      int n;
      @(posedge core_clk_i);
      #1;
      req_i = 1'b1;
      req_read_i = rd;
      req_addr_i = a;
      req_wdata_i = d;
      req_bad_par_i = bp;
      @(posedge core_clk_i);
      #1;
      req_i = 1'b0;
      chk1("busy", 1'b1, busy_o);
      for (n = 0; n < 60 && done_o !== 1'b1; n++) begin
         @(posedge core_clk_i);
         #1;
      end
      chk1("done", 1'b1, done_o);
   endtask

   task automatic chk_int();
      logic exp;
      repeat (3) @(posedge core_clk_i);
      #1;
      exp = (cause & mask) != 0;
      chk1("int_pending", exp, int_pending_o);
      chk1("irq", exp, irq_o);
      chk1("int_line", !exp, port_if.int_n);
   endtask

   task automatic do_write(input logic [5:0] a, input logic [7:0] d, input logic bp);
      int s0;
      s0 = strobe_cnt;
      host_op(SEL_WRITE, a, d, bp);
      if (bp) cause = cause | (1 << PERR_BIT);
      else if (a == CAUSE_IDX) cause = cause & ~int'(d);
      else if (a == MASK_IDX) mask = d;
      else mem[a] = d;
      chk1("wr_strobe", !bp, strobe_cnt == s0 + 1);
      if (!bp) chk8("wr_addr", {2'b00, a}, {2'b00, wr_addr_o});
      if (!bp) chk8("wr_data", d, wr_data_o);
      chk_int();
   endtask

   task automatic do_read(input logic [5:0] a);
      int e;
      host_op(SEL_READ, a, 8'h00, 1'b0);
      e = (a == CAUSE_IDX) ? cause : (a == MASK_IDX) ? mask : mem[a];
      chk8("rdata", 8'(e), rdata_o);
      chk1("rdata_par_err", 1'b0, rdata_par_err_o);
   endtask

   // main sequence
   initial begin
      void'($urandom(32'heecdae37));
      foreach (mem[i]) mem[i] = 0;
      repeat (20) @(posedge core_clk_i);
      #1;
      rst_i = 1'b0;
      chk1("enable_n", 1'b1, port_if.enable_n);
      chk1("ack_n", 1'b1, port_if.ack_n);
      chk1("busy", 1'b0, busy_o);
      $display("test reset done");
      for (int a = 0; a < NUM_REGS; a++) begin
         if (a == CAUSE_IDX || a == MASK_IDX) continue;
         do_read(6'(a));
         do_write(6'(a), 8'($urandom), 1'b0);
      end
      for (int a = 0; a < NUM_REGS; a++) do_read(6'(a));
      $display("test address map done");
      do_write(6'h2a, ~8'(mem[42]), 1'b1);
      do_read(6'h2a);
      do_read(CAUSE_IDX);
      do_write(MASK_IDX, 8'h01, 1'b0);
      do_read(MASK_IDX);
      do_write(CAUSE_IDX, 8'h01, 1'b0);
      $display("test bad parity done");
      for (int k = 0; k < 6; k++) begin
         do_write(MASK_IDX, 8'($urandom), 1'b0);
         ev = 8'($urandom);
         @(posedge core_clk_i);
         #1;
         cond_event_i = ev;
         @(posedge core_clk_i);
         #1;
         cond_event_i = 8'h00;
         cause = cause | ev;
         chk_int();
         do_read(CAUSE_IDX);
         do_write(CAUSE_IDX, ev, 1'b0);
      end
      $display("test interrupts done");
      tally_and_finish();
   end
endmodule
